// ===== rtl/serial_gain_word_loader.sv
// three-wire serial gain word receiver driving the step attenuator
`timescale 1ns/10ps
`default_nettype none
module serial_gain_word_loader (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link from the host
  input wire logic serial_clk,
  input wire logic serial_in_pin,
  input wire logic latch_strobe,
  output logic serial_out_pin,
  // parallel attenuator control
  output gain_loader_pkg::gain_word_t gain_word,
  output gain_loader_pkg::gain_word_t reduction_half_db
);
  import gain_loader_pkg::*;

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  // longest strobe-to-output wait the load checks allow, in clk cycles
  localparam int LOAD_MAX_CYC = STROBE_TO_OUTPUT_CYC;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // attenuation in half-dB steps is the sum of weights of cleared bits
  function automatic gain_word_t reduction_of(input gain_word_t w);
    reduction_of = GAIN_FULL ^ w;
  endfunction

  // ----------------------------------------------------------------
  // link domain: shift register on the serial clock
  // ----------------------------------------------------------------
  link_state_s link_r;
  link_state_s link_nxt;

  // strobe and data are launched by the host against serial_clk, so
  // they are read here without synchronisers; reset does cross over
  always_comb begin
    link_nxt = link_r;
    link_nxt.rst_meta = rst;
    link_nxt.rst_sync = link_r.rst_meta;
    if (link_r.rst_sync) begin
      link_nxt.shift = GAIN_RESET;
    end else if (!latch_strobe) begin
      link_nxt.shift = {link_r.shift[OLDEST_STAGE-1:0], serial_in_pin};
    end
    // strobe high: clock edges are ignored
  end

  // limitation: rst must span at least one rising serial_clk edge, or
  // the link stages keep their old contents; the host idles the clock
  // low between words, so a reset with no edges is simply not seen
  always_ff @(posedge serial_clk) begin
    link_r <= link_nxt;
  end

  // oldest stage feeds the next part in the chain
  assign serial_out_pin = link_r.shift[OLDEST_STAGE];

  // ----------------------------------------------------------------
  // system domain: strobe sync and parallel output
  // ----------------------------------------------------------------
  sys_state_s sys_r;
  sys_state_s sys_nxt;
  logic load_now;

  // shift word is frozen while the strobe is high, so it is safe to
  // sample once the synchronised strobe is seen; costs up to 3 cycles
  assign load_now = sys_r.strobe_sync && !sys_r.strobe_prev;

  always_comb begin
    sys_nxt = sys_r;
    sys_nxt.strobe_meta = latch_strobe;
    sys_nxt.strobe_sync = sys_r.strobe_meta;
    sys_nxt.strobe_prev = sys_r.strobe_sync;
    if (load_now) begin
      sys_nxt.gain_word = link_r.shift;
      sys_nxt.reduction = reduction_of(link_r.shift);
    end
    if (rst) begin
      sys_nxt.strobe_meta = 1'b0;
      sys_nxt.strobe_sync = 1'b0;
      sys_nxt.strobe_prev = 1'b0;
      sys_nxt.gain_word = GAIN_RESET;
      sys_nxt.reduction = reduction_of(GAIN_RESET);
    end
  end

  always_ff @(posedge clk) begin
    sys_r <= sys_nxt;
  end

  assign gain_word = sys_r.gain_word;
  assign reduction_half_db = sys_r.reduction;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // link-side checks run on serial_clk and, but for p_link_reset, stand down until the
  // link reset has passed; clk-side checks but p_reset_min_gain stand down under rst

  // strobe seen low, then high
  sequence s_strobe_rise;
    $rose(latch_strobe);
  endsequence

  // a rise still high one clk later, long enough to load
  sequence s_strobe_held;
    s_strobe_rise ##1 latch_strobe;
  endsequence

  // first clk edge at which the synchronised strobe is new
  sequence s_sync_seen;
    sys_r.strobe_sync && !sys_r.strobe_prev;
  endsequence

  // link edge that really shifts: out of reset, strobe low
  sequence s_link_shift;
    !latch_strobe && !link_r.rst_sync;
  endsequence

  // link edge under a held strobe, out of reset
  sequence s_link_frozen;
    latch_strobe && !link_r.rst_sync;
  endsequence

  // reset drives the minimum gain word and full attenuation
  property p_reset_min_gain;
    @(posedge clk) rst |=> (gain_word == GAIN_RESET) && (reduction_half_db == GAIN_FULL);
  endproperty
  a_reset_min_gain: assert property (p_reset_min_gain) else $error("reset not min gain");

  // loaded word shows within the strobe-to-output budget
  property p_load_delay;
    @(posedge clk) disable iff (rst)
      s_strobe_held |-> ##[1:LOAD_MAX_CYC] (gain_word == link_r.shift);
  endproperty
  a_load_delay: assert property (p_load_delay) else $error("word late on output");

  // synchroniser latency: gain_word may not move on the first clk edge
  property p_no_early_load;
    @(posedge clk) disable iff (rst) s_strobe_rise |=> $stable(gain_word);
  endproperty
  a_no_early_load: assert property (p_no_early_load) else $error("load before sync");

  // between loads the word stands, even while bits are shifting
  property p_hold_between;
    @(posedge clk) disable iff (rst) !load_now |=> $stable(gain_word);
  endproperty
  a_hold_between: assert property (p_hold_between) else $error("word moved w/o strobe");

  // word plus reduction is always the full-scale value
  property p_weights;
    @(posedge clk) disable iff (rst)
      ({1'b0, gain_word} + {1'b0, reduction_half_db}) == {1'b0, GAIN_FULL};
  endproperty
  a_weights: assert property (p_weights) else $error("reduction mismatch");

  // one shift per edge, msb first, newest bit at the bottom
  property p_shift_in;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      s_link_shift |=> (link_r.shift == {$past(link_r.shift[OLDEST_STAGE-1:0]),
                                         $past(serial_in_pin)});
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bad shift");

  // held strobe: edges leave the stages alone
  property p_strobe_freeze;
    @(posedge serial_clk) disable iff (link_r.rst_sync) s_link_frozen |=> $stable(link_r.shift);
  endproperty
  a_strobe_freeze: assert property (p_strobe_freeze) else $error("shift while strobe");

  // six shifting edges carry a bit from input to chain output
  property p_chain_delay;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      (!latch_strobe && !link_r.rst_sync)[*6] |=> serial_out_pin == $past(serial_in_pin, 6);
  endproperty
  a_chain_delay: assert property (p_chain_delay) else $error("chain out delay");

  // a fresh load carries the frozen link word across unchanged
  property p_load_value;
    @(posedge clk) disable iff (rst) s_sync_seen |=> (gain_word == $past(link_r.shift));
  endproperty
  a_load_value: assert property (p_load_value) else $error("loaded word differs");

  // reduction sums the weights of the cleared bits of the loaded word
  property p_load_reduction;
    @(posedge clk) disable iff (rst)
      s_sync_seen |=> (reduction_half_db == (GAIN_FULL ^ $past(link_r.shift)));
  endproperty
  a_load_reduction: assert property (p_load_reduction) else $error("bad reduction");

  // link reset clears every stage, so the chain starts at zero
  property p_link_reset;
    @(posedge serial_clk) link_r.rst_sync |=> (link_r.shift == GAIN_RESET);
  endproperty
  a_link_reset: assert property (p_link_reset) else $error("link not cleared");

  // each shifting edge moves the next-oldest stage to the pin
  property p_chain_step;
    @(posedge serial_clk) disable iff (link_r.rst_sync)
      s_link_shift |=> (serial_out_pin == $past(link_r.shift[OLDEST_STAGE-1]));
  endproperty
  a_chain_step: assert property (p_chain_step) else $error("chain out stage");

  // held strobe also freezes what the next part in the chain sees
  property p_chain_frozen;
    @(posedge serial_clk) disable iff (link_r.rst_sync) s_link_frozen |=> $stable(serial_out_pin);
  endproperty
  a_chain_frozen: assert property (p_chain_frozen) else $error("chain moved");

  // the output word only moves after a load or a reset
  property p_change_has_cause;
    @(posedge clk) disable iff (rst)
      $changed(gain_word) |-> ($past(load_now) || $past(rst));
  endproperty
  a_change_has_cause: assert property (p_change_has_cause) else $error("word moved");

endmodule
`default_nettype wire

// ===== pkg/gain_loader_pkg.sv
// constants and state types for the serial gain word loader
package gain_loader_pkg;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 6;
  typedef logic [WORD_W-1:0] gain_word_t;
  localparam gain_word_t GAIN_RESET = 6'h00;  // all attenuation in, min gain
  localparam gain_word_t GAIN_FULL = 6'h3f;   // all attenuation out, max gain
  localparam int OLDEST_STAGE = WORD_W - 1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_AFTER_CLOCK_GAP_NS = 10;  // host side, min
  localparam int STROBE_SPACING_NS = 630;         // host side, min
  localparam int STROBE_TO_OUTPUT_DELAY_NS = 30;  // device side, max
  // a longest time rounds down, never below one cycle
  localparam int STROBE_TO_OUTPUT_CYC =
    (STROBE_TO_OUTPUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
    (STROBE_TO_OUTPUT_DELAY_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // state of each clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    gain_word_t shift;
  } link_state_s;

  typedef struct packed {
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    gain_word_t gain_word;
    gain_word_t reduction;
  } sys_state_s;

endpackage

// ===== tb/gain_host_model.sv
// host controller model driving the serial gain link
`timescale 1ns/10ps
`default_nettype none
module gain_host_model
  import gain_loader_pkg::*;
(
  // serial link toward the device
  output var logic serial_clk,
  output var logic serial_in_pin,
  output var logic latch_strobe
);
  initial begin
    serial_clk = 1'b0;
    serial_in_pin = 1'b0;
    latch_strobe = 1'b0;
  end
  // msb first at 125 ns, clock idles low
  task automatic shift(input gain_word_t w);
    for (int i = OLDEST_STAGE; i >= 0; i--) begin
      serial_in_pin = w[i];
      #62.5 serial_clk = 1'b1;
      #20 serial_in_pin = ~w[i]; // stale bit flipped once hold runs out
      #42.5 serial_clk = 1'b0;
    end
  endtask
  // strobe well after the last edge, wider than the minimum
  task automatic strobe();
    #20 latch_strobe = 1'b1;
    #40 latch_strobe = 1'b0;
  endtask
  // clocking under a held strobe, spaced from the previous pulse
  task automatic frozen(input gain_word_t w);
    #630 latch_strobe = 1'b1;
    shift(w);
    latch_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/serial_gain_word_loader_bench.sv
// self-checking bench for the serial gain word loader
`timescale 1ns/10ps
`default_nettype none
module serial_gain_word_loader_bench;
  import gain_loader_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic serial_clk, serial_in_pin, latch_strobe;
  logic serial_out_pin;
  gain_word_t gain_word, reduction_half_db;
  int failures = 0;
  int checks_done = 0;
  // full scale, each single step, then zero and two mixed words
  gain_word_t words[10] = '{6'h3f, 6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h2f, 6'h1f, 6'h00, 6'h2a, 6'h15};
  serial_gain_word_loader serial_gain_word_loader_inst (.clk(clk), .rst(rst),
    .serial_clk(serial_clk), .serial_in_pin(serial_in_pin), .latch_strobe(latch_strobe),
    .serial_out_pin(serial_out_pin), .gain_word(gain_word),
    .reduction_half_db(reduction_half_db));
  gain_host_model gain_host_model_inst (.serial_clk(serial_clk),
    .serial_in_pin(serial_in_pin), .latch_strobe(latch_strobe));
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // shift, then latch; output checked 40 ns after the strobe rise
  task automatic load(input gain_word_t w);
    gain_word_t old;
    old = gain_word;
    gain_host_model_inst.shift(w);
    chk("held word", old, gain_word);
    chk("chain out", {5'h00, w[OLDEST_STAGE]}, {5'h00, serial_out_pin});
    gain_host_model_inst.strobe();
    chk("gain_word", w, gain_word);
    chk("reduction", 6'h3f ^ w, reduction_half_db);
  endtask
  // edges under a held strobe must not disturb the stored word
  task automatic freeze(input gain_word_t w);
    gain_host_model_inst.frozen(~w);
    gain_host_model_inst.strobe();
    chk("frozen word", w, gain_word);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  // about 10 us of traffic expected
  initial begin
    #40000;
    failures++;
    close_out();
  end
  initial begin
    // zeros clocked in so the link side sees an edge under reset
    fork
      gain_host_model_inst.shift(6'h00);
    join_none
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // let the six-bit fill finish before the first word
    repeat (64) @(posedge clk);
    #3;
    chk("reset word", GAIN_RESET, gain_word);
    chk("reset chain out", 6'h00, {5'h00, serial_out_pin});
    chk("reset reduction", 6'h3f, reduction_half_db);
    foreach (words[i]) begin
      load(words[i]);
    end
    freeze(6'h15);
    close_out();
  end
endmodule
`default_nettype wire
